// ### inc/pmr_cfg.svh
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

// management device address of this register group
`define PMR_DEVAD            5'h01

// register addresses
`define PMR_OFS_CTRL_ONE     16'h0000
`define PMR_OFS_STAT_ONE     16'h0001
`define PMR_OFS_DEVS_LOW     16'h0005
`define PMR_OFS_DEVS_HIGH    16'h0006
`define PMR_OFS_CTRL_TWO     16'h0007

// field positions
`define PMR_BIT_SOFT_RST     15
`define PMR_BIT_SOFT_PD      11
`define PMR_BIT_LOOPBACK     0
`define PMR_BIT_LINK_LL      2
`define PMR_BIT_PD_ABLE      1
`define PMR_TYPE_MSB         6
`define PMR_TYPE_W           7

// reset and constant values
`define PMR_TYPE_RST         7'h3D
`define PMR_DEVS_LOW_VAL     16'h008B
`define PMR_DEVS_HIGH_VAL    16'hC000
`define PMR_WORD_ZERO        16'h0000

// soft reset duration
`define PMR_CLK_PERIOD_NS    5
`define PMR_SOFT_RST_NS      1000
`define PMR_SOFT_RST_CYC     ((`PMR_SOFT_RST_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)
`define PMR_RST_CNT_W        8
`define PMR_RST_CNT_ZERO     8'h00
`define PMR_RST_CNT_ONE      8'h01

`endif

// ### inc/pmr_pkg.sv
package pmr_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  devad;
        logic [15:0] regad;
        logic [15:0] wdata;
    } pmr_req_t;

    typedef struct packed {
        logic        ack;
        logic        hit;
        logic [15:0] rdata;
    } pmr_rsp_t;

    typedef enum logic [0:0] {
        PMR_SEQ_IDLE = 1'b0,
        PMR_SEQ_RUN  = 1'b1
    } pmr_seq_state_t;

endpackage : pmr_pkg

// ### hw/pmr_rst_seq.sv
`timescale 1ns/1ps
`include "pmr_cfg.svh"

module pmr_rst_seq (
    input  wire logic sys_clk_in,
    input  wire logic resetn_in,
    input  wire logic start_in,
    output logic      busy_out,
    output logic      done_out
);

    localparam int CHK_MAX = 300;

    pmr_pkg::pmr_seq_state_t        state_ff;
    pmr_pkg::pmr_seq_state_t        nxt_state;
    logic [`PMR_RST_CNT_W-1:0]      cnt_ff;
    logic [`PMR_RST_CNT_W-1:0]      nxt_cnt;
    logic                           done_ff;
    logic                           nxt_done;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_done  = 1'b0;
        unique case (state_ff)
            pmr_pkg::PMR_SEQ_IDLE:
            begin
                if (start_in)
                begin
                    nxt_state = pmr_pkg::PMR_SEQ_RUN;
                    nxt_cnt   = `PMR_RST_CNT_W'(`PMR_SOFT_RST_CYC - 1);
                end
            end
            pmr_pkg::PMR_SEQ_RUN:
            begin
                // holds for the whole reset time, then clears itself
                if (cnt_ff == `PMR_RST_CNT_ZERO)
                begin
                    nxt_state = pmr_pkg::PMR_SEQ_IDLE;
                    nxt_done  = 1'b1;
                end
                else
                begin
                    nxt_cnt = cnt_ff - `PMR_RST_CNT_ONE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_ff <= pmr_pkg::PMR_SEQ_IDLE;
            cnt_ff   <= `PMR_RST_CNT_ZERO;
            done_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            done_ff  <= nxt_done;
        end
    end

    assign busy_out = (state_ff == pmr_pkg::PMR_SEQ_RUN);
    assign done_out = done_ff;

    chk_rst_busy_hold: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        $rose(busy_out) |-> busy_out[*8] ##[1:CHK_MAX] (!busy_out && done_out))
        else $error("soft reset busy did not hold then clear");

endmodule : pmr_rst_seq

// ### hw/pmr_regs.sv
`timescale 1ns/1ps
`include "pmr_cfg.svh"

// Overview of operation
// - registers answer only at device address one
// - writing bit 15 starts whole-chip reset
// - reset bit reads one only while resetting
// - bit 11 puts chip in power-down
// - register access still works while powered down
// - power-down default comes from receive-valid strap
// - control word reset value reflects strap
// - bit 0 loops transmit back to receive
// - link bit latches low until read
// - power-down capability bit always reads one
// - low devices word reads constant 0x8B
// - high devices word reads constant 0xC000
// - seven-bit type field, upper bits read-only
// - type field resets to BASE-T1 code
module pmr_regs (
    input  wire logic              sys_clk_in,
    input  wire logic              resetn_in,
    input  wire pmr_pkg::pmr_req_t mgmt_req_in,
    output pmr_pkg::pmr_rsp_t      mgmt_rsp_out,
    input  wire logic              link_up_in,
    input  wire logic              receive_valid_powerdown_strap_pin_in,
    output logic                   chip_soft_reset_out,
    output logic                   soft_power_down_out,
    output logic                   local_loopback_enable_out,
    output logic [6:0]             type_select_out
);

    logic                          strap_done_ff;
    logic                          nxt_strap_done;
    logic                          soft_power_down_bit_ff;
    logic                          nxt_soft_power_down_bit;
    logic                          local_loopback_enable_ff;
    logic                          nxt_local_loopback_enable;
    logic                          latched_link_up_flag_ff;
    logic                          nxt_latched_link_up_flag;
    logic [`PMR_TYPE_W-1:0]        type_sel_ff;
    logic [`PMR_TYPE_W-1:0]        nxt_type_sel;
    pmr_pkg::pmr_rsp_t             rsp_ff;
    pmr_pkg::pmr_rsp_t             nxt_rsp;

    logic                          dev_sel;
    logic                          sel_ctrl_one;
    logic                          sel_stat_one;
    logic                          sel_devs_low;
    logic                          sel_devs_high;
    logic                          sel_ctrl_two;
    logic                          wr_en;
    logic                          rd_en;
    logic                          rst_start;
    logic                          rst_busy;
    logic                          rst_done;

    // decode
    assign dev_sel       = mgmt_req_in.valid && (mgmt_req_in.devad == `PMR_DEVAD);
    assign sel_ctrl_one  = dev_sel && (mgmt_req_in.regad == `PMR_OFS_CTRL_ONE);
    assign sel_stat_one  = dev_sel && (mgmt_req_in.regad == `PMR_OFS_STAT_ONE);
    assign sel_devs_low  = dev_sel && (mgmt_req_in.regad == `PMR_OFS_DEVS_LOW);
    assign sel_devs_high = dev_sel && (mgmt_req_in.regad == `PMR_OFS_DEVS_HIGH);
    assign sel_ctrl_two  = dev_sel && (mgmt_req_in.regad == `PMR_OFS_CTRL_TWO);
    // writes during a soft reset are dropped; the reset would undo them anyway
    assign wr_en         = mgmt_req_in.write && !rst_busy;
    assign rd_en         = !mgmt_req_in.write;
    assign rst_start     = sel_ctrl_one && wr_en
                           && mgmt_req_in.wdata[`PMR_BIT_SOFT_RST];

    pmr_rst_seq pmr_rst_seq_inst (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .start_in   (rst_start),
        .busy_out   (rst_busy),
        .done_out   (rst_done)
    );

    always_comb
    begin
        nxt_strap_done            = 1'b1;
        nxt_soft_power_down_bit   = soft_power_down_bit_ff;
        nxt_local_loopback_enable = local_loopback_enable_ff;
        nxt_type_sel              = type_sel_ff;
        // a drop in the read cycle itself still latches low
        nxt_latched_link_up_flag  = latched_link_up_flag_ff && link_up_in;
        if (sel_stat_one && rd_en)
        begin
            nxt_latched_link_up_flag = link_up_in;
        end
        if (!strap_done_ff || rst_done)
        begin
            // strap caught after hard reset release and at soft reset end
            nxt_soft_power_down_bit   = receive_valid_powerdown_strap_pin_in;
            nxt_local_loopback_enable = 1'b0;
            nxt_type_sel              = `PMR_TYPE_RST;
            nxt_latched_link_up_flag  = 1'b0;
        end
        else
        begin
            if (sel_ctrl_one && wr_en)
            begin
                nxt_soft_power_down_bit   = mgmt_req_in.wdata[`PMR_BIT_SOFT_PD];
                nxt_local_loopback_enable = mgmt_req_in.wdata[`PMR_BIT_LOOPBACK];
            end
            if (sel_ctrl_two && wr_en)
            begin
                nxt_type_sel = mgmt_req_in.wdata[`PMR_TYPE_MSB:0];
            end
        end
    end

    // read path; power-down does not gate it
    always_comb
    begin
        nxt_rsp       = '0;
        nxt_rsp.ack   = mgmt_req_in.valid;
        nxt_rsp.hit   = sel_ctrl_one || sel_stat_one || sel_devs_low
                        || sel_devs_high || sel_ctrl_two;
        nxt_rsp.rdata = `PMR_WORD_ZERO;
        if (rd_en)
        begin
            if (sel_ctrl_one)
            begin
                nxt_rsp.rdata[`PMR_BIT_SOFT_RST] = rst_busy;
                nxt_rsp.rdata[`PMR_BIT_SOFT_PD]  = soft_power_down_bit_ff;
                nxt_rsp.rdata[`PMR_BIT_LOOPBACK] = local_loopback_enable_ff;
            end
            if (sel_stat_one)
            begin
                nxt_rsp.rdata[`PMR_BIT_LINK_LL] = latched_link_up_flag_ff;
                nxt_rsp.rdata[`PMR_BIT_PD_ABLE] = 1'b1;
            end
            if (sel_devs_low)
            begin
                nxt_rsp.rdata = `PMR_DEVS_LOW_VAL;
            end
            if (sel_devs_high)
            begin
                nxt_rsp.rdata = `PMR_DEVS_HIGH_VAL;
            end
            if (sel_ctrl_two)
            begin
                nxt_rsp.rdata[`PMR_TYPE_MSB:0] = type_sel_ff;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            strap_done_ff            <= 1'b0;
            soft_power_down_bit_ff   <= 1'b0;
            local_loopback_enable_ff <= 1'b0;
            latched_link_up_flag_ff  <= 1'b0;
            type_sel_ff              <= `PMR_TYPE_RST;
            rsp_ff                   <= '0;
        end
        else
        begin
            strap_done_ff            <= nxt_strap_done;
            soft_power_down_bit_ff   <= nxt_soft_power_down_bit;
            local_loopback_enable_ff <= nxt_local_loopback_enable;
            latched_link_up_flag_ff  <= nxt_latched_link_up_flag;
            type_sel_ff              <= nxt_type_sel;
            rsp_ff                   <= nxt_rsp;
        end
    end

    assign mgmt_rsp_out              = rsp_ff;
    assign chip_soft_reset_out       = rst_busy;
    assign soft_power_down_out       = soft_power_down_bit_ff;
    assign local_loopback_enable_out = local_loopback_enable_ff;
    assign type_select_out           = type_sel_ff;

    chk_ack_every_req: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        mgmt_req_in.valid |=> mgmt_rsp_out.ack)
        else $error("request not acknowledged next cycle");

    chk_other_devad_miss: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        mgmt_req_in.valid && (mgmt_req_in.devad != `PMR_DEVAD)
        |=> !mgmt_rsp_out.hit && (mgmt_rsp_out.rdata == `PMR_WORD_ZERO))
        else $error("foreign device address answered");

    chk_soft_rst_start: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        rst_start |=> chip_soft_reset_out[*4])
        else $error("soft reset did not start");

    chk_rst_bit_reads: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        sel_ctrl_one && rd_en
        |=> mgmt_rsp_out.rdata[`PMR_BIT_SOFT_RST] == $past(chip_soft_reset_out))
        else $error("reset bit read disagrees with reset state");

    chk_pd_write: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        sel_ctrl_one && wr_en && strap_done_ff && !rst_done
        |=> soft_power_down_out == $past(mgmt_req_in.wdata[`PMR_BIT_SOFT_PD]))
        else $error("power-down bit not written");

    chk_pd_access: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        soft_power_down_out && sel_devs_high && rd_en
        |=> mgmt_rsp_out.hit && (mgmt_rsp_out.rdata == `PMR_DEVS_HIGH_VAL))
        else $error("access lost in power-down");

    // the release edge itself still resets; the strap load is one edge later
    chk_strap_load: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        resetn_in && (!strap_done_ff || rst_done)
        |=> soft_power_down_out == $past(receive_valid_powerdown_strap_pin_in)
            && !local_loopback_enable_out)
        else $error("strap not captured into power-down");

    chk_loopback_write: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        sel_ctrl_one && wr_en && strap_done_ff && !rst_done
        |=> local_loopback_enable_out == $past(mgmt_req_in.wdata[`PMR_BIT_LOOPBACK]))
        else $error("loopback bit not written");

    chk_link_latch_low: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        !link_up_in ##1 (sel_stat_one && rd_en)
        |=> !mgmt_rsp_out.rdata[`PMR_BIT_LINK_LL])
        else $error("link drop not latched");

    chk_status_read: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        sel_stat_one && rd_en
        |=> mgmt_rsp_out.rdata[`PMR_BIT_PD_ABLE] && (mgmt_rsp_out.rdata[15:3] == 13'h0000))
        else $error("status capability or reserved bits wrong");

    chk_devs_low_const: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        sel_devs_low && rd_en |=> mgmt_rsp_out.rdata == `PMR_DEVS_LOW_VAL)
        else $error("low devices word wrong");

    chk_type_reserved: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        sel_ctrl_two && rd_en
        |=> mgmt_rsp_out.rdata == {9'h000, $past(type_sel_ff)})
        else $error("type word read wrong");

    chk_link_recover: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        strap_done_ff && !rst_done && sel_stat_one && rd_en && link_up_in
        ##1 (link_up_in && !rst_done)[*2]
        ##1 (link_up_in && sel_stat_one && rd_en)
        |=> mgmt_rsp_out.rdata[`PMR_BIT_LINK_LL])
        else $error("latched link did not recover");

endmodule : pmr_regs

// ### dv/pmr_host_model.sv
`timescale 1ns/1ps

module pmr_host_model (
    input  wire pmr_pkg::pmr_rsp_t rsp_in,
    input  wire logic              sys_clk_in,
    output pmr_pkg::pmr_req_t      req_out
);
    initial
    begin
        req_out = '0;
    end

    // one access: driven after an edge, taken at the next, answer seen one edge later
    task automatic xfer(
        input  logic              wr,
        input  logic [4:0]        dev,
        input  logic [15:0]       ra,
        input  logic [15:0]       wd,
        output pmr_pkg::pmr_rsp_t rsp
    );
        @(posedge sys_clk_in);
        req_out <= '{valid: 1'b1, write: wr, devad: dev, regad: ra, wdata: wd};
        @(posedge sys_clk_in);
        // released fields flip so a stale value never passes as a live one
        req_out <= '{valid: 1'b0, write: ~wr, devad: ~dev, regad: ~ra, wdata: ~wd};
        @(posedge sys_clk_in);
        rsp = rsp_in;
    endtask : xfer
endmodule : pmr_host_model

// ### dv/tb_pmr_regs.sv
`timescale 1ns/1ps
`include "pmr_cfg.svh"

module tb_pmr_regs;
    logic              sys_clk_in;
    logic              resetn_in;
    logic              link_up_in;
    logic              strap_in;
    logic              soft_rst;
    logic              pd;
    logic              lb;
    logic [6:0]        type_sel;
    pmr_pkg::pmr_req_t mgmt_req;
    pmr_pkg::pmr_rsp_t mgmt_rsp;
    int                errors;
    int                n_tests;

    pmr_regs pmr_regs_inst (
        .sys_clk_in                           (sys_clk_in),
        .resetn_in                            (resetn_in),
        .mgmt_req_in                          (mgmt_req),
        .mgmt_rsp_out                         (mgmt_rsp),
        .link_up_in                           (link_up_in),
        .receive_valid_powerdown_strap_pin_in (strap_in),
        .chip_soft_reset_out                  (soft_rst),
        .soft_power_down_out                  (pd),
        .local_loopback_enable_out            (lb),
        .type_select_out                      (type_sel)
    );

    pmr_host_model pmr_host_model_inst (
        .rsp_in     (mgmt_rsp),
        .sys_clk_in (sys_clk_in),
        .req_out    (mgmt_req)
    );

    initial
    begin
        sys_clk_in = 1'b0;
    end

    always #2.5 sys_clk_in = ~sys_clk_in;

    task automatic test_done;
        if (errors == 0 && n_tests > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [4:0] dev, input logic [15:0] ra,
                       input logic [15:0] wd, input logic hit, input logic [15:0] exp);
        pmr_pkg::pmr_rsp_t rsp;
        pmr_host_model_inst.xfer(wr, dev, ra, wd, rsp);
        chk("ack", 16'h0001, {15'h0000, rsp.ack});
        chk("hit", {15'h0000, hit}, {15'h0000, rsp.hit});
        chk("rdata", exp, rsp.rdata);
    endtask : acc

    task automatic rd(input logic [15:0] ra, input logic [15:0] exp);
        acc(1'b0, `PMR_DEVAD, ra, 16'h0000, 1'b1, exp);
    endtask : rd

    task automatic wr(input logic [15:0] ra, input logic [15:0] wd);
        acc(1'b1, `PMR_DEVAD, ra, wd, 1'b1, 16'h0000);
    endtask : wr

    task automatic t_defaults;
        rd(`PMR_OFS_CTRL_ONE, 16'h0800);
        chk("pd_out", 16'h0001, {15'h0000, pd});
        rd(`PMR_OFS_STAT_ONE, 16'h0002);
        rd(`PMR_OFS_DEVS_LOW, 16'h008B);
        rd(`PMR_OFS_DEVS_HIGH, 16'hC000);
        rd(`PMR_OFS_CTRL_TWO, 16'h003D);
        chk("type_out", 16'h003D, {9'h000, type_sel});
    endtask : t_defaults

    task automatic t_ctrl_one;
        wr(`PMR_OFS_CTRL_ONE, 16'h7FFF);
        rd(`PMR_OFS_CTRL_ONE, 16'h0801);
        chk("pd_out", 16'h0001, {15'h0000, pd});
        chk("lb_out", 16'h0001, {15'h0000, lb});
        wr(`PMR_OFS_CTRL_ONE, 16'h0000);
        rd(`PMR_OFS_CTRL_ONE, 16'h0000);
        chk("lb_out", 16'h0000, {15'h0000, lb});
    endtask : t_ctrl_one

    task automatic t_ctrl_two;
        wr(`PMR_OFS_CTRL_TWO, 16'hFFC2);
        rd(`PMR_OFS_CTRL_TWO, 16'h0042);
        chk("type_out", 16'h0042, {9'h000, type_sel});
        wr(`PMR_OFS_DEVS_LOW, 16'hFFFF);
        wr(`PMR_OFS_DEVS_HIGH, 16'h0000);
        rd(`PMR_OFS_DEVS_LOW, 16'h008B);
        rd(`PMR_OFS_DEVS_HIGH, 16'hC000);
    endtask : t_ctrl_two

    task automatic t_foreign;
        acc(1'b0, 5'h02, `PMR_OFS_CTRL_ONE, 16'h0000, 1'b0, 16'h0000);
        acc(1'b1, 5'h02, `PMR_OFS_CTRL_ONE, 16'h0801, 1'b0, 16'h0000);
        acc(1'b1, 5'h03, `PMR_OFS_CTRL_TWO, 16'h0001, 1'b0, 16'h0000);
        acc(1'b0, `PMR_DEVAD, 16'h0002, 16'h0000, 1'b0, 16'h0000);
        rd(`PMR_OFS_CTRL_ONE, 16'h0000);
        rd(`PMR_OFS_CTRL_TWO, 16'h0042);
    endtask : t_foreign

    task automatic t_link;
        rd(`PMR_OFS_STAT_ONE, 16'h0006);
        @(posedge sys_clk_in);
        link_up_in <= 1'b0;
        @(posedge sys_clk_in);
        link_up_in <= 1'b1;
        rd(`PMR_OFS_STAT_ONE, 16'h0002);
        link_up_in <= 1'b0;
        rd(`PMR_OFS_STAT_ONE, 16'h0002);
        link_up_in <= 1'b1;
        rd(`PMR_OFS_STAT_ONE, 16'h0002);
        rd(`PMR_OFS_STAT_ONE, 16'h0006);
    endtask : t_link

    task automatic t_soft_reset;
        logic [15:0] cnt;
        strap_in <= 1'b0;
        cnt = 16'h0000;
        wr(`PMR_OFS_CTRL_ONE, 16'h8801);
        chk("rst_out", 16'h0001, {15'h0000, soft_rst});
        rd(`PMR_OFS_CTRL_ONE, 16'h8801);
        wr(`PMR_OFS_CTRL_ONE, 16'h0000);
        rd(`PMR_OFS_CTRL_ONE, 16'h8801);
        // 200-cycle run: nine edges already spent by the accesses above
        while (soft_rst === 1'b1 && cnt < 16'h0190)
        begin
            @(posedge sys_clk_in);
            cnt++;
        end
        chk("rst_cycles", 16'h00BF, cnt);
        rd(`PMR_OFS_CTRL_ONE, 16'h0000);
        chk("pd_out", 16'h0000, {15'h0000, pd});
        chk("lb_out", 16'h0000, {15'h0000, lb});
        rd(`PMR_OFS_CTRL_TWO, 16'h003D);
        chk("type_out", 16'h003D, {9'h000, type_sel});
        rd(`PMR_OFS_STAT_ONE, 16'h0002);
    endtask : t_soft_reset

    task automatic t_hard_reset;
        wr(`PMR_OFS_CTRL_ONE, 16'h0001);
        wr(`PMR_OFS_CTRL_TWO, 16'h0055);
        strap_in <= 1'b1;
        resetn_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        chk("pd_out", 16'h0001, {15'h0000, pd});
        chk("lb_out", 16'h0000, {15'h0000, lb});
        rd(`PMR_OFS_CTRL_ONE, 16'h0800);
        rd(`PMR_OFS_CTRL_TWO, 16'h003D);
        rd(`PMR_OFS_STAT_ONE, 16'h0002);
    endtask : t_hard_reset

    initial
    begin
        errors = 0;
        n_tests = 0;
        resetn_in = 1'b0;
        link_up_in = 1'b1;
        strap_in = 1'b1;
        repeat (12) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        t_defaults();
        t_ctrl_one();
        t_ctrl_two();
        t_foreign();
        t_link();
        t_soft_reset();
        t_hard_reset();
        test_done();
    end

    // whole run is near 330 cycles; twelve times that means a hang
    initial
    begin
        repeat (4000) @(posedge sys_clk_in);
        errors++;
        test_done();
    end
endmodule : tb_pmr_regs
